//--- logic/flash_seq_pkg.sv
package flash_seq_pkg;
	// ----------------------------------------
	// address map and command bytes
	// ----------------------------------------
	localparam logic [15:0] CTRL_ADDR     = 16'h0FFF;
	localparam logic [15:0] PROT_ADDR     = 16'hFF7F;
	localparam logic [15:0] ID_MAKER_ADDR = 16'hF000;
	localparam logic [15:0] ID_MACRO_ADDR = 16'hF001;
	localparam logic [15:0] ID_SIZE_ADDR  = 16'hF002;
	localparam logic [15:0] BANK0_OFFSET  = 16'h8000;
	localparam logic [15:0] CHIP_FIRST    = 16'h1000;
	localparam logic [15:0] CHIP_LAST     = 16'hFFFF;
	localparam logic [11:0] SECT_LAST     = 12'hFFF;
	localparam logic [11:0] UNL1_OFS      = 12'h555;
	localparam logic [11:0] UNL2_OFS      = 12'hAAA;
	localparam logic [3:0]  MCU_MIN_AREA  = 4'h1;
	localparam logic [3:0]  BANK0_MIN     = 4'h9;
	localparam logic [3:0]  BANK1_MIN     = 4'h8;
	localparam logic [7:0]  UNL1_DATA     = 8'hAA;
	localparam logic [7:0]  UNL2_DATA     = 8'h55;
	localparam logic [7:0]  CMD_PROG      = 8'hA0;
	localparam logic [7:0]  CMD_ERASE     = 8'h80;
	localparam logic [7:0]  CMD_SECTOR    = 8'h30;
	localparam logic [7:0]  CMD_CHIP      = 8'h10;
	localparam logic [7:0]  CMD_ID        = 8'h90;
	localparam logic [7:0]  CMD_EXIT      = 8'hF0;
	localparam logic [7:0]  CMD_PROT      = 8'hA5;
	localparam logic [7:0]  PROT_DATA     = 8'h00;
	localparam logic [7:0]  ERASED        = 8'hFF;
	localparam logic [7:0]  STAT_UNPROT   = 8'hFF;
	localparam logic [7:0]  STAT_PROT     = 8'h00;
	// size codes: 60K 48K 32K 24K 16K 8K 4K
	localparam logic [7:0]  SIZE_60K = 8'h0E;
	localparam logic [7:0]  SIZE_48K = 8'h0B;
	localparam logic [7:0]  SIZE_32K = 8'h07;
	localparam logic [7:0]  SIZE_24K = 8'h05;
	localparam logic [7:0]  SIZE_16K = 8'h03;
	localparam logic [7:0]  SIZE_8K  = 8'h01;
	localparam logic [7:0]  SIZE_4K  = 8'h00;
	// identity values are arbitrary
	localparam logic [7:0]  MAKER_ID = 8'h5A;
	localparam logic [7:0]  MACRO_ID = 8'h3C;
	// ----------------------------------------
	// control register layout
	// ----------------------------------------
	localparam int          SEQ_EN_LSB = 4;
	localparam int          BANK_BIT   = 3;
	localparam logic [3:0]  SEQ_EN_ON  = 4'h3;
	localparam logic [3:0]  SEQ_EN_RST = 4'hC;
	localparam logic        BANK_RST   = 1'b1;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ       = 200;
	localparam int PROG_TIME_US  = 40;
	localparam int ERASE_TIME_MS = 30;
	localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_CYCLES  = ERASE_TIME_MS * 1000 * CLK_MHZ;
	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_UNL1 = 9'h002,
		ST_UNL2 = 9'h004,
		ST_PROG = 9'h008,
		ST_ERA3 = 9'h010,
		ST_ERA4 = 9'h020,
		ST_ERA5 = 9'h040,
		ST_PROT = 9'h080,
		ST_BUSY = 9'h100
	} seq_state_e;
endpackage

//--- logic/flash_command_sequencer.sv
// Function
// - unlock offsets match low twelve bits only
// - top nibble must lie in mode area
// - program: AA, 55, A0, then data
// - sector erase: six writes ending 30H
// - sector picked from mapped top nibble
// - chip erase ends 10H, array reads FFH
// - chip erase busy about thirty milliseconds
// - program done within forty microseconds
// - sector erase done within thirty milliseconds
// - commands ignored while operation busy
// - busy reads invert bit six each time
// - first status read returns toggle one
// - AA, 55, 90H enters identification mode
// - id mode returns maker, macro, size, protect
// - size code encodes flash capacity
// - F0H single or triple write exits id
// - AA, 55, A5H, 00H@FF7FH sets protect
// - protection blocks programmer reads, boot commands in boot mode only
// - only chip erase or reset clears protection
// - commands accepted only with enable 0011B
// - boot bank zero maps high to low
`timescale 1ns/100ps
module flash_command_sequencer #(
	parameter int PROG_CYCLES  = flash_seq_pkg::PROG_CYCLES,
	parameter int ERASE_CYCLES = flash_seq_pkg::ERASE_CYCLES
) (
	input  wire logic        core_clk_i,        // system clock
	input  wire logic        rstn_i,            // async reset
	input  wire logic [15:0] avs_address_i,     // cpu byte address
	input  wire logic        avs_read_i,        // read request
	input  wire logic        avs_write_i,       // write request
	input  wire logic [7:0]  avs_writedata_i,   // write byte
	output logic      [7:0]  avs_readdata_o,    // read byte
	output logic             avs_waitrequest_o, // stall
	input  wire logic        boot_mode_i,       // boot mode pin
	output logic             busy_o,            // operation running
	output logic             id_mode_o,         // identification mode
	output logic             prot_o,            // read protection set
	output logic             par_read_block_o,  // programmer reads off
	output logic             boot_cmd_block_o   // boot commands off
);
	// ----------------------------------------
	// storage and state
	// ----------------------------------------
	logic [7:0]  mem [0:65535];
	flash_seq_pkg::seq_state_e state;
	flash_seq_pkg::seq_state_e next_state;
	logic [3:0]  seq_enable_field;
	logic        bank_sel;
	logic        boot_meta;
	logic        boot_sync;
	logic        wait_q;
	logic        toggle_status_bit;
	logic        erase_act;
	logic        chip_op;
	logic [15:0] erase_ptr;
	logic [15:0] erase_end;
	logic [22:0] cnt;
	logic [15:0] idx;
	logic        valid;
	logic        xfer;
	logic        wr_x;
	logic        rd_x;
	logic        cmd_wr;
	logic        m_unl1;
	logic        m_unl2;
	logic        at555;
	logic        op_done;
	logic        start_prog;
	logic        start_sect;
	logic        start_chip;
	logic        start_prot;
	logic        start_any;
	logic        id_enter;
	logic        id_exit;
	logic [7:0]  rd_val;
	logic [7:0]  wd;
	logic [15:0] adr;

	assign adr = avs_address_i;
	assign wd  = avs_writedata_i;

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	// boot strap arrives from a pin, two stages
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			boot_meta <= 1'b0;
			boot_sync <= 1'b0;
		end else begin
			boot_meta <= boot_mode_i;
			boot_sync <= boot_meta;
		end
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	// one wait cycle: read data are built before
	// the edge where waitrequest is seen low
	assign xfer = (avs_read_i | avs_write_i) & ~wait_q;
	assign wr_x = xfer & avs_write_i;
	assign rd_x = xfer & avs_read_i;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wait_q <= 1'b1;
		end else if (xfer) begin
			wait_q <= 1'b1;
		end else if (avs_read_i | avs_write_i) begin
			wait_q <= 1'b0;
		end
	end
	assign avs_waitrequest_o = wait_q;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			avs_readdata_o <= 8'h00;
		end else if (avs_read_i && wait_q) begin
			avs_readdata_o <= rd_val;
		end
	end

	// control register; reserved enable codes are kept
	// but still disable, since only one code enables
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			seq_enable_field <= flash_seq_pkg::SEQ_EN_RST;
			bank_sel         <= flash_seq_pkg::BANK_RST;
		end else if (wr_x && adr == flash_seq_pkg::CTRL_ADDR) begin
			seq_enable_field <= wd[flash_seq_pkg::SEQ_EN_LSB+:4];
			bank_sel         <= wd[flash_seq_pkg::BANK_BIT];
		end
	end

	// ----------------------------------------
	// address mapping
	// ----------------------------------------
	// area check and boot bank translation
	always_comb begin
		idx = adr;
		if (!boot_sync) begin
			valid = adr[15:12] >= flash_seq_pkg::MCU_MIN_AREA;
		end else if (!bank_sel) begin
			valid = adr[15:12] >= flash_seq_pkg::BANK0_MIN;
			idx   = adr - flash_seq_pkg::BANK0_OFFSET;
		end else begin
			valid = adr[15:12] >= flash_seq_pkg::BANK1_MIN;
		end
	end

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	// only low offset bits take part in unlock match
	assign at555  = adr[11:0] == flash_seq_pkg::UNL1_OFS;
	assign m_unl1 = at555 && wd == flash_seq_pkg::UNL1_DATA;
	assign m_unl2 = adr[11:0] == flash_seq_pkg::UNL2_OFS
		&& wd == flash_seq_pkg::UNL2_DATA;
	// busy or disabled writes never reach the decoder
	assign cmd_wr = wr_x && valid && state != flash_seq_pkg::ST_BUSY
		&& seq_enable_field == flash_seq_pkg::SEQ_EN_ON;
	assign op_done = cnt == 23'h000000 && !erase_act;

	always_comb begin
		next_state = state;
		start_prog = 1'b0;
		start_sect = 1'b0;
		start_chip = 1'b0;
		start_prot = 1'b0;
		id_enter   = 1'b0;
		id_exit    = 1'b0;
		unique case (state)
		flash_seq_pkg::ST_IDLE: begin
			if (cmd_wr) begin
				next_state = m_unl1 ? flash_seq_pkg::ST_UNL1
					: flash_seq_pkg::ST_IDLE;
				id_exit = wd == flash_seq_pkg::CMD_EXIT;
			end
		end
		flash_seq_pkg::ST_UNL1: begin
			if (cmd_wr) begin
				next_state = m_unl2 ? flash_seq_pkg::ST_UNL2
					: flash_seq_pkg::ST_IDLE;
			end
		end
		flash_seq_pkg::ST_UNL2: begin
			if (cmd_wr) begin
				next_state = flash_seq_pkg::ST_IDLE;
				if (at555) begin
					unique case (wd)
					flash_seq_pkg::CMD_PROG:
						next_state = flash_seq_pkg::ST_PROG;
					flash_seq_pkg::CMD_ERASE:
						next_state = flash_seq_pkg::ST_ERA3;
					flash_seq_pkg::CMD_PROT:
						next_state = flash_seq_pkg::ST_PROT;
					flash_seq_pkg::CMD_ID:
						id_enter = 1'b1;
					flash_seq_pkg::CMD_EXIT:
						id_exit = 1'b1;
					default: ;
					endcase
				end
			end
		end
		flash_seq_pkg::ST_PROG: begin
			if (cmd_wr) begin
				start_prog = 1'b1;
				next_state = flash_seq_pkg::ST_BUSY;
			end
		end
		flash_seq_pkg::ST_ERA3: begin
			if (cmd_wr) begin
				next_state = m_unl1 ? flash_seq_pkg::ST_ERA4
					: flash_seq_pkg::ST_IDLE;
			end
		end
		flash_seq_pkg::ST_ERA4: begin
			if (cmd_wr) begin
				next_state = m_unl2 ? flash_seq_pkg::ST_ERA5
					: flash_seq_pkg::ST_IDLE;
			end
		end
		flash_seq_pkg::ST_ERA5: begin
			if (cmd_wr) begin
				next_state = flash_seq_pkg::ST_IDLE;
				if (wd == flash_seq_pkg::CMD_SECTOR) begin
					start_sect = 1'b1;
				end else if (at555 && wd == flash_seq_pkg::CMD_CHIP) begin
					start_chip = 1'b1;
				end
				if (start_sect || start_chip) begin
					next_state = flash_seq_pkg::ST_BUSY;
				end
			end
		end
		flash_seq_pkg::ST_PROT: begin
			if (cmd_wr) begin
				next_state = flash_seq_pkg::ST_IDLE;
				if (adr == flash_seq_pkg::PROT_ADDR
					&& wd == flash_seq_pkg::PROT_DATA) begin
					start_prot = 1'b1;
					next_state = flash_seq_pkg::ST_BUSY;
				end
			end
		end
		flash_seq_pkg::ST_BUSY: begin
			if (op_done) begin
				next_state = flash_seq_pkg::ST_IDLE;
			end
		end
		endcase
	end
	assign start_any = start_prog | start_sect | start_chip | start_prot;

	// disabled or out-of-area writes, except to the control register, also drop a partial sequence
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= flash_seq_pkg::ST_IDLE;
		end else if (wr_x && adr != flash_seq_pkg::CTRL_ADDR && !cmd_wr
			&& state != flash_seq_pkg::ST_BUSY) begin
			state <= flash_seq_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end
	assign busy_o = state[8];

	// ----------------------------------------
	// operation timing
	// ----------------------------------------
	// erase timer also waits for the sweep, so a short
	// simulation value can never cut an erase short
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 23'h000000;
		end else if (start_prog || start_prot) begin
			cnt <= 23'(PROG_CYCLES - 1);
		end else if (start_sect || start_chip) begin
			cnt <= 23'(ERASE_CYCLES - 1);
		end else if (cnt != 23'h000000) begin
			cnt <= cnt - 23'h000001;
		end
	end

	// one byte erased per cycle across the chosen range
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			erase_act <= 1'b0;
			chip_op   <= 1'b0;
			erase_ptr <= 16'h0000;
			erase_end <= 16'h0000;
		end else if (start_sect) begin
			erase_act <= 1'b1;
			chip_op   <= 1'b0;
			erase_ptr <= {idx[15:12], 12'h000};
			erase_end <= {idx[15:12], flash_seq_pkg::SECT_LAST};
		end else if (start_chip) begin
			erase_act <= 1'b1;
			chip_op   <= 1'b1;
			erase_ptr <= flash_seq_pkg::CHIP_FIRST;
			erase_end <= flash_seq_pkg::CHIP_LAST;
		end else if (erase_act) begin
			erase_act <= erase_ptr != erase_end;
			erase_ptr <= erase_ptr + 16'h0001;
		end
	end

	// array writes: program byte or erase sweep
	always_ff @(posedge core_clk_i) begin
		if (start_prog) begin
			mem[idx] <= wd;
		end else if (erase_act) begin
			mem[erase_ptr] <= flash_seq_pkg::ERASED;
		end
	end

	// ----------------------------------------
	// toggle, id mode, protection
	// ----------------------------------------
	// toggle preset to one so the first poll sees one
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			toggle_status_bit <= 1'b0;
		end else if (start_any) begin
			toggle_status_bit <= 1'b1;
		end else if (rd_x && busy_o) begin
			toggle_status_bit <= ~toggle_status_bit;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			id_mode_o <= 1'b0;
		end else if (id_enter) begin
			id_mode_o <= 1'b1;
		end else if (id_exit) begin
			id_mode_o <= 1'b0;
		end
	end

	// held in a flop: survives everything but reset and chip erase
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prot_o           <= 1'b0;
			boot_cmd_block_o <= 1'b0;
		end else begin
			if (start_prot) begin
				prot_o <= 1'b1;
			end else if (start_chip) begin
				prot_o <= 1'b0;
			end
			boot_cmd_block_o <= prot_o & boot_sync;
		end
	end
	assign par_read_block_o = prot_o;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_comb begin
		rd_val = 8'h00;
		if (adr == flash_seq_pkg::CTRL_ADDR) begin
			rd_val = {seq_enable_field, bank_sel, 3'b000};
		end else if (valid) begin
			rd_val = mem[idx];
			if (busy_o) begin
				rd_val[6] = toggle_status_bit;
			end else if (id_mode_o) begin
				unique case (adr)
				flash_seq_pkg::ID_MAKER_ADDR:
					rd_val = flash_seq_pkg::MAKER_ID;
				flash_seq_pkg::ID_MACRO_ADDR:
					rd_val = flash_seq_pkg::MACRO_ID;
				flash_seq_pkg::ID_SIZE_ADDR:
					rd_val = flash_seq_pkg::SIZE_60K;
				flash_seq_pkg::PROT_ADDR:
					rd_val = prot_o ? flash_seq_pkg::STAT_PROT
						: flash_seq_pkg::STAT_UNPROT;
				default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_disabled_no_cmd: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		wr_x && seq_enable_field != flash_seq_pkg::SEQ_EN_ON
		&& state != flash_seq_pkg::ST_BUSY
		|=> state == flash_seq_pkg::ST_IDLE)
		else $error("command taken while disabled");
	a_busy_ignores_cmd: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		busy_o && !op_done |=> busy_o && !$rose(erase_act))
		else $error("command accepted while busy");
	a_first_toggle_one: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		start_any |=> toggle_status_bit && busy_o)
		else $error("first toggle not one");
	a_toggle_flips: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		rd_x && busy_o && !start_any
		|=> toggle_status_bit != $past(toggle_status_bit))
		else $error("toggle bit did not flip");
	a_prog_time_cap: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		start_prog |=> cnt == 23'(PROG_CYCLES - 1) && !erase_act)
		else $error("program time wrong");
	a_sector_pick: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		start_sect |=> erase_ptr[15:12] == $past(idx[15:12])
		&& erase_ptr[11:0] == 12'h000 && erase_act)
		else $error("wrong sector chosen");
	a_chip_clears_prot: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		start_chip |=> !prot_o && chip_op ##1 !prot_o)
		else $error("chip erase kept protection");
	a_prot_sets: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		start_prot |=> prot_o ##1 boot_cmd_block_o == boot_sync)
		else $error("protection not set");
	a_break_to_idle: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		state == flash_seq_pkg::ST_UNL1 && cmd_wr && !m_unl2
		|=> state == flash_seq_pkg::ST_IDLE)
		else $error("broken sequence kept");
	a_id_entry: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		id_enter |=> id_mode_o && state == flash_seq_pkg::ST_IDLE)
		else $error("id mode not entered");
endmodule // flash_command_sequencer

//--- sim/cpu_bus_model.sv
`timescale 1ns/100ps
module cpu_bus_model (
	input  wire logic        core_clk_i,    // system clock
	input  wire logic        waitrequest_i, // slave stall
	input  wire logic [7:0]  readdata_i,    // read byte
	output logic      [15:0] address_o,     // byte address
	output logic             read_o,        // read strobe
	output logic             write_o,       // write strobe
	output logic      [7:0]  writedata_o    // write byte
);
	// ----------------------------------------
	// idle bus and one transfer
	// ----------------------------------------
	initial begin
		address_o   = 16'h0000;
		read_o      = 1'b0;
		write_o     = 1'b0;
		writedata_o = 8'h00;
	end

	// held until waitrequest is sampled low, then released
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge core_clk_i);
		address_o   <= a;
		writedata_o <= d;
		write_o     <= w;
		read_o      <= !w;
		do @(posedge core_clk_i); while (waitrequest_i !== 1'b0);
		q = readdata_i;
		read_o      <= 1'b0;
		write_o     <= 1'b0;
		// released lines change so nothing stale looks valid
		address_o   <= ~a;
		writedata_o <= ~d;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] q);
		xfer(1'b0, a, 8'h00, q);
	endtask

	// poll one address until two reads agree
	task automatic poll(input logic [15:0] a, output logic [7:0] f,
		output int n);
		logic [7:0] q0;
		logic [7:0] q1;
		rd(a, q0);
		f = q0;
		n = 1;
		forever begin
			rd(a, q1);
			n++;
			if (q1 === q0) break;
			q0 = q1;
		end
	endtask
endmodule // cpu_bus_model

//--- sim/test_flash_command_sequencer.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
	checks++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module test_flash_command_sequencer;
	localparam int PC = 20;  // shortened program time
	localparam int EC = 100; // shortened erase time, sweep dominates
	logic        core_clk_i = 1'b0;
	logic        rstn_i     = 1'b0;
	logic        boot_mode  = 1'b0;
	logic [15:0] address;
	logic        rd_s;
	logic        wr_s;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        waitreq;
	logic        busy;
	logic        id_mode;
	logic        prot;
	logic        par_blk;
	logic        boot_blk;
	int          err_total  = 0;
	int          checks     = 0;
	int          bl         = 0;
	int          last_bl    = 0;

	// ----------------------------------------
	// clock, parts, busy span meter
	// ----------------------------------------
	always #2.5 core_clk_i = ~core_clk_i;

	flash_command_sequencer #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) dut_u (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.avs_address_i(address), .avs_read_i(rd_s), .avs_write_i(wr_s),
		.avs_writedata_i(wdata), .avs_readdata_o(rdata),
		.avs_waitrequest_o(waitreq), .boot_mode_i(boot_mode),
		.busy_o(busy), .id_mode_o(id_mode), .prot_o(prot),
		.par_read_block_o(par_blk), .boot_cmd_block_o(boot_blk));

	cpu_bus_model cpu_u (
		.core_clk_i(core_clk_i), .waitrequest_i(waitreq),
		.readdata_i(rdata), .address_o(address), .read_o(rd_s),
		.write_o(wr_s), .writedata_o(wdata));

	// length of the last busy span, in cycles
	always @(posedge core_clk_i) begin
		if (busy === 1'b1) bl <= bl + 1;
		else begin
			if (bl != 0) last_bl <= bl;
			bl <= 0;
		end
	end

	// ----------------------------------------
	// sequence helpers
	// ----------------------------------------
	task automatic unlock(input logic [3:0] hi);
		cpu_u.wr({hi, flash_seq_pkg::UNL1_OFS}, flash_seq_pkg::UNL1_DATA);
		cpu_u.wr({hi, flash_seq_pkg::UNL2_OFS}, flash_seq_pkg::UNL2_DATA);
	endtask

	task automatic cmd(input logic [3:0] hi, input logic [7:0] c);
		unlock(hi);
		cpu_u.wr({hi, flash_seq_pkg::UNL1_OFS}, c);
	endtask

	task automatic prog(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] f;
		int         n;
		cmd(4'h1, flash_seq_pkg::CMD_PROG);
		cpu_u.wr(a, d);
		cpu_u.poll(a, f, n);
	endtask

	task automatic boot_sel(input logic b);
		@(posedge core_clk_i);
		boot_mode <= b;
		repeat (3) @(posedge core_clk_i); // two-flop sync settles
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_disabled();
		logic [7:0] q;
		cpu_u.rd(flash_seq_pkg::CTRL_ADDR, q);
		`CHK(q, 8'hC8)
		cmd(4'h1, flash_seq_pkg::CMD_PROG);
		cpu_u.wr(16'h1234, 8'h00);
		#1;
		`CHK(busy, 1'b0)
		// reserved enable code is stored but must still disable
		cpu_u.wr(flash_seq_pkg::CTRL_ADDR, 8'h58);
		cpu_u.rd(flash_seq_pkg::CTRL_ADDR, q);
		`CHK(q, 8'h58)
		cmd(4'h1, flash_seq_pkg::CMD_PROG);
		cpu_u.wr(16'h1234, 8'h00);
		#1;
		`CHK(busy, 1'b0)
	endtask

	task automatic t_protect();
		logic [7:0] q;
		logic [7:0] f;
		int         n;
		boot_sel(1'b1);
		cpu_u.wr(flash_seq_pkg::CTRL_ADDR, 8'h38); // bank one first
		cmd(4'h8, flash_seq_pkg::CMD_PROT);
		cpu_u.wr(flash_seq_pkg::PROT_ADDR, flash_seq_pkg::PROT_DATA);
		cpu_u.poll(16'h8000, f, n);
		`CHK(f[6], 1'b1)
		`CHK(last_bl inside {[PC - 1:PC + 4]}, 1'b1)
		#1;
		`CHK({prot, par_blk, boot_blk}, 3'b111)
		cmd(4'h8, flash_seq_pkg::CMD_ID);
		cpu_u.rd(flash_seq_pkg::PROT_ADDR, q);
		`CHK(q, flash_seq_pkg::STAT_PROT)
		cpu_u.wr(16'h8000, flash_seq_pkg::CMD_EXIT);
		boot_sel(1'b0);
		#1;
		`CHK({prot, par_blk, boot_blk}, 3'b110)
	endtask

	task automatic t_chip_erase();
		logic [15:0] al [4] = '{16'h1000, 16'h5000, 16'h8000, 16'hFFFF};
		logic [7:0]  q;
		logic [7:0]  f;
		int          n;
		cmd(4'h1, flash_seq_pkg::CMD_ERASE);
		cmd(4'h1, flash_seq_pkg::CMD_CHIP);
		// a program attempt while busy must leave no trace;
		// aimed behind the sweep so the erase cannot hide it
		cmd(4'h1, flash_seq_pkg::CMD_PROG);
		cpu_u.wr(16'h1000, 8'h00);
		cpu_u.poll(16'h1555, f, n);
		`CHK(f[6], 1'b1)
		`CHK(last_bl inside {[61439:61460]}, 1'b1)
		`CHK({prot, par_blk}, 2'b00)
		for (int i = 0; i < 4; i++) begin
			cpu_u.rd(al[i], q);
			`CHK(q, flash_seq_pkg::ERASED)
		end
	endtask

	task automatic t_program();
		logic [7:0] q;
		logic [7:0] f;
		int         n;
		cmd(4'h7, flash_seq_pkg::CMD_PROG); // top nibble is not matched
		cpu_u.wr(16'h2345, 8'h5A); // location erased beforehand
		cpu_u.poll(16'h2345, f, n);
		`CHK(f[6], 1'b1)
		`CHK(n >= 3, 1'b1)
		`CHK(last_bl inside {[PC - 1:PC + 4]}, 1'b1)
		cpu_u.rd(16'h2345, q);
		`CHK(q, 8'h5A)
		cpu_u.rd(16'h2345, q);
		`CHK(q, 8'h5A)
	endtask

	task automatic t_sector();
		logic [7:0] q;
		logic [7:0] f;
		int         n;
		prog(16'h2100, 8'h11);
		prog(16'h3100, 8'h22);
		cmd(4'h1, flash_seq_pkg::CMD_ERASE);
		unlock(4'h1);
		cpu_u.wr(16'h2ABC, flash_seq_pkg::CMD_SECTOR);
		cpu_u.poll(16'h2ABC, f, n);
		`CHK(last_bl inside {[4095:4116]}, 1'b1)
		cpu_u.rd(16'h2100, q);
		`CHK(q, flash_seq_pkg::ERASED)
		cpu_u.rd(16'h3100, q);
		`CHK(q, 8'h22)
	endtask

	task automatic t_broken();
		logic [7:0] q;
		cmd(4'h1, 8'h12); // wrong third byte
		cpu_u.wr(16'h1555, flash_seq_pkg::CMD_PROG);
		cpu_u.wr(16'h4000, 8'h00);
		unlock(4'h1);
		cpu_u.wr(16'h0555, flash_seq_pkg::CMD_PROG); // area zero
		cpu_u.wr(16'h4001, 8'h00);
		#1;
		`CHK(busy, 1'b0)
		cpu_u.rd(16'h4000, q);
		`CHK(q, flash_seq_pkg::ERASED)
		cpu_u.rd(16'h4001, q);
		`CHK(q, flash_seq_pkg::ERASED)
		prog(16'h4002, 8'h66);
		cpu_u.rd(16'h4002, q);
		`CHK(q, 8'h66)
	endtask

	task automatic t_id();
		logic [15:0] ia [4] = '{flash_seq_pkg::ID_MAKER_ADDR,
			flash_seq_pkg::ID_MACRO_ADDR, flash_seq_pkg::ID_SIZE_ADDR,
			flash_seq_pkg::PROT_ADDR};
		logic [7:0]  iv [4] = '{flash_seq_pkg::MAKER_ID,
			flash_seq_pkg::MACRO_ID, flash_seq_pkg::SIZE_60K,
			flash_seq_pkg::STAT_UNPROT};
		logic [7:0]  q;
		cmd(4'h1, flash_seq_pkg::CMD_ID);
		#1;
		`CHK(id_mode, 1'b1)
		for (int i = 0; i < 4; i++) begin
			cpu_u.rd(ia[i], q);
			`CHK(q, iv[i])
		end
		cpu_u.wr(16'h1234, flash_seq_pkg::CMD_EXIT);
		#1;
		`CHK(id_mode, 1'b0)
		cpu_u.rd(flash_seq_pkg::ID_MAKER_ADDR, q);
		`CHK(q, flash_seq_pkg::ERASED)
		cmd(4'h1, flash_seq_pkg::CMD_ID);
		#1;
		`CHK(id_mode, 1'b1)
		cmd(4'h1, flash_seq_pkg::CMD_EXIT);
		#1;
		`CHK(id_mode, 1'b0)
	endtask

	task automatic t_boot_bank();
		logic [7:0] q;
		logic [7:0] f;
		int         n;
		boot_sel(1'b1);
		cpu_u.wr(flash_seq_pkg::CTRL_ADDR, 8'h30); // bank zero
		cmd(4'h9, flash_seq_pkg::CMD_PROG);
		cpu_u.wr(16'hF010, 8'h3F);
		cpu_u.poll(16'hF010, f, n);
		cpu_u.wr(flash_seq_pkg::CTRL_ADDR, 8'h38);
		boot_sel(1'b0);
		cpu_u.rd(16'h7010, q);
		`CHK(q, 8'h3F)
		cpu_u.rd(16'hF010, q);
		`CHK(q, flash_seq_pkg::ERASED)
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic wrap_up();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// chip erase sweep dominates; about a third over the run
	initial begin
		#450000;
		err_total++;
		wrap_up();
	end

	initial begin
		repeat (16) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		t_disabled();
		t_protect();
		t_chip_erase();
		t_program();
		t_sector();
		t_broken();
		t_id();
		t_boot_bank();
		wrap_up();
	end
endmodule // test_flash_command_sequencer
